/* supervisor_defines.svh */
// Purpose: Constants for the supervisor: times, addresses, fields
// Assumes: 100 MHz system clock
// Notes:   Times kept in their own unit; cycle counts derived in RTL
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH
// Clock rate and unit steps
`define CLK_MHZ       32'h0000_0064
`define US_PER_MS     32'h0000_03E8
// Times as printed
`define CLOSED_WIN_MS 32'h0000_0064
`define HOLD_BASE_MS  32'h0000_0004
`define TSHD_MS       32'h0000_0080
`define FILTER_US     32'h0000_0004
`define TX_TO_MS      32'h0000_0004
// Window scale in percent per fuse code
`define PCT_DIV       32'h0000_0064
`define PCT_NOM       32'h0000_0064
`define PCT_M40       32'h0000_003C
`define PCT_M20       32'h0000_0050
`define PCT_P20       32'h0000_0078
`define PCT_P60       32'h0000_00A0
`define PCT_P100      32'h0000_00C8
// Register addresses
`define A_CTRL        3'h0
`define A_RELAY       3'h1
`define A_DIAG        3'h2
`define A_TRIG        3'h3
`define A_STAT        3'h4
// Control bits and reset value
`define C_SHDN        0
`define C_SLEW        1
`define C_TMON        2
`define C_RLYOFF      3
`define CTRL_RST      4'h4
// Diagnostic bits
`define D_WARN        0
`define D_TXTO        1
`define D_WDRST       2
// Synchroniser lanes and reset levels
`define S_POR         0
`define S_UV          1
`define S_OT          2
`define S_WARN        3
`define S_OV          4
`define S_TX          5
`define SYNC_RST      6'h20
`endif

/* supervisor_pkg.sv */
// Purpose: Types shared by the supervisor
// Assumes: Nothing beyond SystemVerilog
// Notes:   Watchdog states are one-hot
package supervisor_pkg;
  // Watchdog phases
  typedef enum logic [3:0] {
    WD_OFF    = 4'h1,
    WD_CLOSED = 4'h2,
    WD_OPEN   = 4'h4,
    WD_RESET  = 4'h8
  } wd_state_e;
  // Factory fuse bundle
  typedef struct packed {
    logic       wd_en;
    logic [2:0] win_sel;
    logic [1:0] uv_sel;
    logic [1:0] hold_sel;
  } fuse_s;
endpackage

/* supervisor_reset_watchdog.sv */
// Purpose: Reset combiner, window watchdog and safe-state forcing
// Assumes: Analog comparators arrive as asynchronous levels
// Notes:   Supply power-on reset acts as master reset
// Function
// - Missed window holds reset for hold time
// - Late or early trigger pulls reset low
// - Fuse enables watchdog, 3-bit selects window
// - Watchdog starts after external reset releases
// - Rail undervoltage switches watchdog off
// - Rail reset releases after good hold time
// - Rail reset asserts after dropout filter delay
// - Rail reset inits watchdog and transmit timers, not control or shutdown timer
// - External reset combines rail and watchdog
// - Shutdowns reach reset only through rail
// - 2-bit fuse selects rail threshold
// - Supply reset overrides, stops regulator, transceiver
// - Supply reset loads control reset value, clears diagnostics
// - After supply reset, normal mode, regulator and transceiver on, relays off
// - Supply drop cancels reduced slew selection
// - Over-temperature powers down until return
// - Warning sets diagnostic flag, enable bit
// - Long transmit low releases bus recessive
// - Watchdog reset or timeout forces relays off
// - Battery overvoltage holds relays off
// - Control bit requests regulator shutdown
// - Hold time selectable 4/8/16/32 ms
// - Closed window 0-100 ms trigger resets
// - Open window 100-200 ms trigger accepted
`timescale 1ns/1ns
`include "supervisor_defines.svh"
module supervisor_reset_watchdog #(
  parameter logic [31:0] CLOSED_CYC =
    `CLOSED_WIN_MS * `US_PER_MS * `CLK_MHZ,
  parameter logic [31:0] HOLD_BASE_CYC =
    `HOLD_BASE_MS * `US_PER_MS * `CLK_MHZ,
  parameter logic [31:0] TSHD_CYC =
    `TSHD_MS * `US_PER_MS * `CLK_MHZ,
  parameter logic [31:0] TX_TO_CYC =
    `TX_TO_MS * `US_PER_MS * `CLK_MHZ
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rstn,
  input  wire logic                  supply_por_n,
  input  wire logic                  rail_uv,
  input  wire logic                  over_temp,
  input  wire logic                  temp_warn,
  input  wire logic                  bat_ov,
  input  wire logic                  tx_in_n,
  input  wire supervisor_pkg::fuse_s fuse,
  input  wire logic [2:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [7:0]                 reg_rdata,
  output logic                       ext_reset_n,
  output logic                       regulator_on,
  output logic                       transceiver_on,
  output logic                       low_slew,
  output logic                       lin_dominant,
  output logic [1:0]                 relay_drv,
  output logic [1:0]                 uv_thresh_sel
);
  localparam int NS = 6;
  // Dropout filter in cycles, short enough for a constant
  localparam logic [31:0] FILT_CYC = `FILTER_US * `CLK_MHZ;
  // Per-lane synchroniser reset levels
  localparam logic [NS-1:0] SYNC_INIT = `SYNC_RST;

  // Window length scaled by fuse code
  function automatic logic [31:0] win_cyc(input logic [2:0] sel);
    logic [31:0] pct;
    pct = `PCT_NOM;
    unique case (sel)
      3'h1:    pct = `PCT_M40;
      3'h2:    pct = `PCT_M20;
      3'h3:    pct = `PCT_P20;
      3'h4:    pct = `PCT_P60;
      3'h5:    pct = `PCT_P100;
      default: pct = `PCT_NOM;
    endcase
    return (CLOSED_CYC * pct) / `PCT_DIV;
  endfunction

  logic [NS-1:0]             raw;      // Asynchronous levels
  logic [NS-1:0]             s1_q;     // First stage
  logic [NS-1:0]             s2_q;     // Second stage
  logic [NS-1:0]             s3_q;     // Third stage
  logic [NS-1:0]             filt_q;   // Agreed levels
  supervisor_pkg::fuse_s     fuse_q;   // Sampled fuses
  supervisor_pkg::wd_state_e wd_q;     // Watchdog phase
  logic [31:0]               wd_cnt_q; // Watchdog timer
  logic [31:0]               rc_q;     // Rail filter timer
  logic                      rail_ok_q;
  logic                      ext_q;
  logic [3:0]                ctrl_q;   // Control register
  logic [31:0]               sd_cnt_q; // Shutdown timer
  logic [2:0]                diag_q;   // Diagnostic flags
  logic [31:0]               tx_cnt_q; // Dominant timer
  logic                      tx_to_q;  // Transmit timed out
  logic [1:0]                relay_q;  // Driver data register
  logic [1:0]                relay_drv_q;
  logic                      reg_on_q;
  logic                      trx_on_q;
  logic                      lin_dom_q;
  logic [1:0]                uvsel_q;
  logic [7:0]                rdata_q;
  logic                      por_ok;   // Supply good
  logic                      mrst;     // Master reset
  logic                      wd_trig;  // Service trigger
  logic                      therm_off;
  logic [31:0]               closed_c;
  logic [31:0]               hold_c;
  logic [2:0]                diag_set;

  assign raw = {tx_in_n, bat_ov, temp_warn, over_temp, rail_uv,
                supply_por_n};
  assign por_ok = filt_q[`S_POR];
  assign mrst = !rstn || !por_ok;
  assign wd_trig = reg_wr && (reg_addr == `A_TRIG);
  assign closed_c = win_cyc(fuse_q.win_sel);
  assign hold_c = HOLD_BASE_CYC << fuse_q.hold_sel;
  assign therm_off = ctrl_q[`C_TMON] && filt_q[`S_OT];

  // Three-stage synchronisers, change taken when stages agree
  for (genvar i = 0; i < NS; i++) begin : g_sync
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        s1_q[i]   <= SYNC_INIT[i];
        s2_q[i]   <= SYNC_INIT[i];
        s3_q[i]   <= SYNC_INIT[i];
        filt_q[i] <= SYNC_INIT[i];
      end else begin
        s1_q[i] <= raw[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          filt_q[i] <= s3_q[i];
        end
      end
    end
  end

  // Fuse capture after reset
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      fuse_q  <= '0;
      uvsel_q <= 2'h0;
    end else begin
      fuse_q  <= fuse;
      uvsel_q <= fuse_q.uv_sel;
    end
  end

  // Rail reset: one timer counts the disagreeing condition
  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      rail_ok_q <= 1'b0;
      rc_q      <= '0;
    end else if (filt_q[`S_UV] == rail_ok_q) begin
      if (rc_q >= (rail_ok_q ? FILT_CYC : hold_c)) begin
        rail_ok_q <= !rail_ok_q;
        rc_q      <= '0;
      end else begin
        rc_q <= rc_q + 32'h0000_0001;
      end
    end else begin
      rc_q <= '0;
    end
  end

  // External reset from rail and watchdog
  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= rail_ok_q && (wd_q != supervisor_pkg::WD_RESET);
    end
  end

  // Window watchdog sequencer
  always_ff @(posedge sys_clk) begin
    if (mrst || !rail_ok_q) begin
      wd_q     <= supervisor_pkg::WD_OFF;
      wd_cnt_q <= '0;
    end else begin
      unique case (wd_q)
        supervisor_pkg::WD_OFF: begin
          wd_cnt_q <= '0;
          if (fuse_q.wd_en && ext_q) begin
            wd_q <= supervisor_pkg::WD_CLOSED;
          end
        end
        supervisor_pkg::WD_CLOSED: begin
          if (!fuse_q.wd_en) begin
            wd_q <= supervisor_pkg::WD_OFF;
          end else if (wd_trig) begin
            wd_q     <= supervisor_pkg::WD_RESET;
            wd_cnt_q <= '0;
          end else begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
            if (wd_cnt_q + 32'h0000_0001 >= closed_c) begin
              wd_q <= supervisor_pkg::WD_OPEN;
            end
          end
        end
        supervisor_pkg::WD_OPEN: begin
          if (!fuse_q.wd_en) begin
            wd_q <= supervisor_pkg::WD_OFF;
          end else if (wd_trig) begin
            wd_q     <= supervisor_pkg::WD_CLOSED;
            wd_cnt_q <= '0;
          end else if (wd_cnt_q + 32'h0000_0001 >= (closed_c << 1)) begin
            wd_q     <= supervisor_pkg::WD_RESET;
            wd_cnt_q <= '0;
          end else begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
          end
        end
        supervisor_pkg::WD_RESET: begin
          if (wd_cnt_q + 32'h0000_0001 >= hold_c) begin
            wd_q     <= supervisor_pkg::WD_OFF;
            wd_cnt_q <= '0;
          end else begin
            wd_cnt_q <= wd_cnt_q + 32'h0000_0001;
          end
        end
        default: begin
          wd_q     <= supervisor_pkg::WD_OFF;
          wd_cnt_q <= '0;
        end
      endcase
    end
  end

  // Control register, kept through rail reset
  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      ctrl_q   <= `CTRL_RST;
      sd_cnt_q <= '0;
    end else begin
      if (ctrl_q[`C_SHDN]) begin
        sd_cnt_q <= sd_cnt_q + 32'h0000_0001;
      end else begin
        sd_cnt_q <= '0;
      end
      if (reg_wr && reg_addr == `A_CTRL) begin
        // Software write wins over timer clear
        ctrl_q <= reg_wdata[3:0];
      end else if (ctrl_q[`C_SHDN] && sd_cnt_q + 32'h0000_0001 >= TSHD_CYC) begin
        ctrl_q[`C_SHDN] <= 1'b0;
      end
    end
  end

  // Power enables
  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      reg_on_q <= 1'b0;
      trx_on_q <= 1'b0;
    end else begin
      reg_on_q <= !ctrl_q[`C_SHDN] && !therm_off;
      trx_on_q <= !ctrl_q[`C_SHDN] && !therm_off;
    end
  end

  // Diagnostic flags, write one to clear, set wins
  always_comb begin
    diag_set = 3'h0;
    diag_set[`D_WARN]  = ctrl_q[`C_TMON] && filt_q[`S_WARN];
    diag_set[`D_TXTO]  = tx_to_q;
    diag_set[`D_WDRST] = wd_q == supervisor_pkg::WD_RESET;
  end

  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      diag_q <= 3'h0;
    end else if (reg_wr && reg_addr == `A_DIAG) begin
      diag_q <= (diag_q & ~reg_wdata[2:0]) | diag_set;
    end else begin
      diag_q <= diag_q | diag_set;
    end
  end

  // Transmit dominant timeout
  always_ff @(posedge sys_clk) begin
    if (mrst || !rail_ok_q) begin
      tx_cnt_q <= '0;
      tx_to_q  <= 1'b0;
    end else if (filt_q[`S_TX]) begin
      tx_cnt_q <= '0;
      tx_to_q  <= 1'b0;
    end else if (!tx_to_q) begin
      if (tx_cnt_q + 32'h0000_0001 >= TX_TO_CYC) begin
        tx_to_q <= 1'b1;
      end
      tx_cnt_q <= tx_cnt_q + 32'h0000_0001;
    end
  end

  // Bus drive
  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      lin_dom_q <= 1'b0;
    end else begin
      lin_dom_q <= trx_on_q && !filt_q[`S_TX] && !tx_to_q;
    end
  end

  // Relay data register and forced-off gating
  always_ff @(posedge sys_clk) begin
    if (mrst) begin
      relay_q     <= 2'h0;
      relay_drv_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `A_RELAY) begin
        relay_q <= reg_wdata[1:0];
      end
      if (wd_q == supervisor_pkg::WD_RESET || tx_to_q ||
          filt_q[`S_OV] || ctrl_q[`C_RLYOFF]) begin
        relay_drv_q <= 2'h0;
      end else begin
        relay_drv_q <= relay_q;
      end
    end
  end

  // Read port, data one cycle after strobe
  always_ff @(posedge sys_clk) begin
    if (mrst || !rail_ok_q) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        `A_CTRL:  rdata_q <= {4'h0, ctrl_q};
        `A_RELAY: rdata_q <= {6'h00, relay_q};
        `A_DIAG:  rdata_q <= {5'h00, diag_q};
        `A_STAT:  rdata_q <= {ext_q, rail_ok_q, tx_to_q, therm_off,
                              wd_q};
        default:  rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata      = rdata_q;
  assign ext_reset_n    = ext_q;
  assign regulator_on   = reg_on_q;
  assign transceiver_on = trx_on_q;
  assign low_slew       = ctrl_q[`C_SLEW];
  assign lin_dominant   = lin_dom_q;
  assign relay_drv      = relay_drv_q;
  assign uv_thresh_sel  = uvsel_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_wd_live;
    por_ok && rail_ok_q && fuse_q.wd_en;
  endsequence
  sequence s_trig_closed;
    s_wd_live ##0 wd_trig && wd_q == supervisor_pkg::WD_CLOSED;
  endsequence
  sequence s_trig_open;
    s_wd_live ##0 wd_trig && wd_q == supervisor_pkg::WD_OPEN;
  endsequence

  AST_EARLY_TRIG: assert property (
    s_trig_closed |=> wd_q == supervisor_pkg::WD_RESET ##1 !ext_q)
    else $error("early trigger did not reset");
  AST_OPEN_TRIG: assert property (
    s_trig_open |=> wd_q == supervisor_pkg::WD_CLOSED && wd_cnt_q == 0)
    else $error("open trigger did not restart");
  AST_RST_COMBINE: assert property (
    por_ok && !rail_ok_q |=> !ext_q)
    else $error("rail reset not on output");
  AST_WD_OFF_UV: assert property (
    !rail_ok_q |=> wd_q == supervisor_pkg::WD_OFF)
    else $error("watchdog alive under rail reset");
  AST_WD_WAIT: assert property (
    wd_q == supervisor_pkg::WD_OFF && !ext_q |=>
      wd_q == supervisor_pkg::WD_OFF)
    else $error("watchdog started under reset");
  AST_UV_FILT: assert property (
    por_ok && rail_ok_q && filt_q[`S_UV] && rc_q == FILT_CYC |=>
      !rail_ok_q ##1 !ext_q)
    else $error("rail reset not after filter");
  AST_POR_STOP: assert property (
    !por_ok |=> !reg_on_q && !trx_on_q && ctrl_q == `CTRL_RST)
    else $error("supply reset did not stop");
  AST_RELAY_OFF: assert property (
    tx_to_q || filt_q[`S_OV] |=> relay_drv_q == 2'h0)
    else $error("relay not forced off");
  AST_TX_RELEASE: assert property (
    $rose(tx_to_q) |=> !lin_dom_q)
    else $error("bus held dominant after timeout");
  AST_WARN: assert property (
    por_ok && ctrl_q[`C_TMON] && filt_q[`S_WARN] |=> diag_q[`D_WARN])
    else $error("warning flag not set");
endmodule

/* host_mcu_model.sv */
// Purpose: Host that services the watchdog over the register port
// Assumes: Register port samples strobes on the rising edge
// Notes:   Bench tasks and the service loop never overlap
`timescale 1ns/1ns
module host_mcu_model (
  input  wire logic       sys_clk,
  input  wire logic       svc_en,
  input  wire logic [7:0] svc_gap,
  input  wire logic [7:0] reg_rdata,
  output logic      [2:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  logic own_q;  // Service write in flight
  int   cnt_q;  // Cycles since last trigger

  // Idle bus at time zero
  initial begin
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    own_q = 1'b0;
    cnt_q = 0;
  end

  always @(posedge sys_clk) begin
    if (svc_en && cnt_q == svc_gap) begin
      reg_addr <= 3'h3;
      reg_wdata <= 8'hA5;
      reg_wr <= 1'b1;
      own_q <= 1'b1;
      cnt_q <= 0;
    end else begin
      cnt_q <= svc_en ? cnt_q + 1 : 0;
      // Drop strobe, scramble released data
      if (own_q) begin
        reg_wr <= 1'b0;
        reg_wdata <= 8'h5A;
        own_q <= 1'b0;
      end
    end
  end

  // One-cycle write, data scrambled after, one idle edge
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~v;
    @(posedge sys_clk);
  endtask

  // One-cycle read, data taken one cycle later
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    v = reg_rdata;
  endtask
endmodule

/* tb_supervisor_reset_watchdog.sv */
// Purpose: Self-checking bench for the supervisor
// Assumes: Shortened counts: closed 40, hold 8, shutdown 20, tx 30
// Notes:   Waits of 8 cycles cover the input synchronisers
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
  fails++; $display("Error %s expected %0h seen %0h", n, e, g); end end
module tb_supervisor_reset_watchdog;
  logic                  sys_clk, rstn, supply_por_n, rail_uv;
  logic                  over_temp, temp_warn, bat_ov, tx_in_n;
  logic                  svc_en, reg_wr, reg_rd, ext_reset_n;
  logic                  regulator_on, transceiver_on, low_slew;
  logic                  lin_dominant;
  supervisor_pkg::fuse_s fuse;
  logic [2:0]            reg_addr;
  logic [7:0]            reg_wdata, reg_rdata, d, svc_gap;
  logic [1:0]            relay_drv, uv_thresh_sel;
  int                    fails, check_count, n;
  int                    pct[8] = '{100, 60, 80, 120, 160, 200, 100, 100};

  // Device with shortened counts
  supervisor_reset_watchdog #(
    .CLOSED_CYC    (32'h0000_0028),
    .HOLD_BASE_CYC (32'h0000_0008),
    .TSHD_CYC      (32'h0000_0014),
    .TX_TO_CYC     (32'h0000_001E)
  ) supervisor_reset_watchdog_i (
    .sys_clk, .rstn, .supply_por_n, .rail_uv, .over_temp, .temp_warn,
    .bat_ov, .tx_in_n, .fuse, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .ext_reset_n, .regulator_on, .transceiver_on,
    .low_slew, .lin_dominant, .relay_drv, .uv_thresh_sel
  );

  // Host on the register port
  host_mcu_model host_mcu_model_i (
    .sys_clk, .svc_en, .svc_gap, .reg_rdata, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd
  );

  // 100 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic w(input logic [2:0] a, input logic [7:0] v);
    host_mcu_model_i.wr(a, v);
  endtask

  task automatic r(input logic [2:0] a);
    host_mcu_model_i.rd(a, d);
  endtask

  // Bounded wait for a reset level, cycles waited in n
  task automatic wait_ext(input logic l, input int lim);
    n = 0;
    while (ext_reset_n !== l && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    `CHK("ext_wait", l, ext_reset_n)
  endtask

  // Count cycles with reset not high
  task automatic lows(input int k);
    n = 0;
    repeat (k) begin
      @(posedge sys_clk);
      if (ext_reset_n !== 1'b1) n++;
    end
  endtask

  // Reset for 4 cycles, then wait for release
  task automatic do_reset;
    rstn <= 1'b0;
    cyc(4);
    rstn <= 1'b1;
    wait_ext(1'b1, 400);
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic close_out;
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Hang guard
  initial begin
    cyc(20000);
    fails++;
    close_out;
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    supply_por_n = 1'b1;
    rail_uv = 1'b0;
    over_temp = 1'b0;
    temp_warn = 1'b0;
    bat_ov = 1'b0;
    tx_in_n = 1'b1;
    svc_en = 1'b0;
    svc_gap = 8'h2D;
    fuse = '{1'b1, 3'h0, 2'h0, 2'h0};
    // Every window and hold code, missed window
    for (int k = 0; k < 8; k++) begin
      fuse <= '{1'b1, k[2:0], ~k[1:0], k[1:0]};
      do_reset;
      `CHK("uv_sel", ~k[1:0], uv_thresh_sel)
      `CHK("reg_on", 1'b1, regulator_on)
      wait_ext(1'b0, 600);
      `CHK("wd_win", 1'b1, n > 80*pct[k]/100 && n < 80*pct[k]/100+4)
      wait_ext(1'b1, 200);
      `CHK("hold", 1'b1, n >= 8<<k[1:0] && n <= (8<<k[1:0])+2)
    end
    done("window");
    fuse <= '{1'b1, 3'h0, 2'h0, 2'h0};
    do_reset;
    cyc(2);
    r(3'h4);
    `CHK("status", 8'hC2, d)
    w(3'h1, 8'h03);
    cyc(2);
    `CHK("relay", 2'h3, relay_drv)
    w(3'h3, 8'hA5);
    wait_ext(1'b0, 3);
    cyc(1);
    `CHK("relay_wd", 2'h0, relay_drv)
    wait_ext(1'b1, 20);
    r(3'h2);
    `CHK("diag_wd", 1'b1, d[2])
    r(3'h5);
    `CHK("unmapped", 8'h00, d)
    svc_en <= 1'b1;
    lows(300);
    `CHK("svc_fast", 0, n)
    svc_gap <= 8'h4B;
    lows(400);
    `CHK("svc_slow", 0, n)
    svc_en <= 1'b0;
    done("watchdog");
    fuse <= '{1'b0, 3'h0, 2'h0, 2'h0};
    do_reset;
    w(3'h3, 8'hA5);
    lows(300);
    `CHK("wd_off", 0, n)
    w(3'h0, 8'h06);
    cyc(2);
    `CHK("slew", 1'b1, low_slew)
    rail_uv <= 1'b1;
    lows(300);
    `CHK("uv_short", 0, n)
    rail_uv <= 1'b0;
    cyc(8);
    rail_uv <= 1'b1;
    wait_ext(1'b0, 450);
    `CHK("uv_filt", 1'b1, n > 400 && n < 410)
    rail_uv <= 1'b0;
    wait_ext(1'b1, 40);
    `CHK("uv_hold", 1'b1, n > 8 && n < 17)
    r(3'h0);
    `CHK("ctrl_kept", 8'h06, d)
    done("rail");
    supply_por_n <= 1'b0;
    cyc(8);
    `CHK("por_ext", 1'b0, ext_reset_n)
    `CHK("por_pwr", 2'h0, {regulator_on, transceiver_on})
    `CHK("por_slew", 1'b0, low_slew)
    supply_por_n <= 1'b1;
    wait_ext(1'b1, 100);
    `CHK("por_on", 2'h3, {regulator_on, transceiver_on})
    r(3'h0);
    `CHK("por_ctrl", 8'h04, d)
    done("supply");
    over_temp <= 1'b1;
    cyc(8);
    `CHK("ot_off", 1'b0, regulator_on)
    `CHK("ot_ext", 1'b1, ext_reset_n)
    over_temp <= 1'b0;
    cyc(8);
    `CHK("ot_back", 1'b1, regulator_on)
    temp_warn <= 1'b1;
    cyc(8);
    temp_warn <= 1'b0;
    r(3'h2);
    `CHK("warn", 8'h01, d)
    cyc(4);
    w(3'h2, 8'h01);
    w(3'h0, 8'h00);
    temp_warn <= 1'b1;
    cyc(8);
    temp_warn <= 1'b0;
    r(3'h2);
    `CHK("warn_dis", 8'h00, d)
    done("thermal");
    w(3'h1, 8'h03);
    bat_ov <= 1'b1;
    cyc(8);
    `CHK("ov_off", 2'h0, relay_drv)
    bat_ov <= 1'b0;
    cyc(8);
    `CHK("ov_back", 2'h3, relay_drv)
    tx_in_n <= 1'b0;
    cyc(8);
    `CHK("tx_dom", 1'b1, lin_dominant)
    cyc(30);
    `CHK("tx_rel", 1'b0, lin_dominant)
    `CHK("tx_relay", 2'h0, relay_drv)
    tx_in_n <= 1'b1;
    w(3'h0, 8'h05);
    cyc(4);
    `CHK("shdn", 1'b0, regulator_on)
    cyc(30);
    `CHK("shdn_end", 1'b1, regulator_on)
    r(3'h0);
    `CHK("shdn_clr", 8'h04, d)
    done("safe_state");
    close_out;
  end
endmodule
